// file: swk_top.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "swk_defines.svh"

module swk_top (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       internal_low_speed_rc,
    input  wire logic       external_low_speed_crystal,
    input  wire logic       cpu_idle,
    input  wire logic       cpu_power_down,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata_q,
    output logic            irq_q,
    output logic            wake_request_q,
    output logic            rc_keep_on_q,
    output logic            xtal_keep_on_q
);

    swk_pkg::swk_bus_t  bus;
    swk_pkg::swk_ctrl_t ctrl_q;
    swk_pkg::swk_ctrl_t ctrl_d;

    logic       flag_q;
    logic       flag_d;
    logic [7:0] reload_q;
    logic [7:0] reload_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [1:0] enable_q;
    logic [1:0] enable_d;
    logic [7:0] rdata_d;
    logic       irq_d;
    logic       wake_d;
    logic       rc_on_d;
    logic       xtal_on_d;
    logic       src_prev_q;
    logic       src_prev_d;

    logic       rc_sync;
    logic       xtal_sync;
    logic       src_level;
    logic       src_edge;
    logic       tick;
    logic       overflow;
    logic       low_power;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign low_power = cpu_idle || cpu_power_down;

    // ----------------------------------------
    // low-speed clock sampling
    // ----------------------------------------
    swk_sync u_rc_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (internal_low_speed_rc),
        .sync_out (rc_sync)
    );

    swk_sync u_xtal_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (external_low_speed_crystal),
        .sync_out (xtal_sync)
    );

    // source mux after the synchronisers; a mid-run swap is software's fault
    assign src_level = ctrl_q.clk_src ? xtal_sync : rc_sync;
    // edge detect only valid while core clock outruns twice the source
    assign src_edge = src_level && !src_prev_q;

    always_comb begin
        src_prev_d = src_prev_q;
        if (clk_en) begin
            src_prev_d = src_level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_prev_d;
        end
    end

    swk_prescale u_prescale (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .run      (ctrl_q.run),
        .src_edge (src_edge),
        .prescale (ctrl_q.prescale),
        .tick     (tick)
    );

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // idle and power-down are deliberately not looked at here
    assign overflow = tick && (count_q == `SWK_COUNT_TOP);

    always_comb begin
        count_d = count_q;
        if (clk_en) begin
            if (tick) begin
                if (overflow) begin
                    count_d = reload_q;
                end else begin
                    count_d = count_q + 8'h01;
                end
            end else if (bus.wr && bus.addr == `SWK_ADDR_RELOAD && !ctrl_q.run) begin
                // preload so the first period matches the reload
                count_d = bus.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q <= `SWK_RST_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_comb begin
        ctrl_d   = ctrl_q;
        flag_d   = flag_q;
        reload_d = reload_q;
        status_d = status_q;
        mask_d   = mask_q;
        enable_d = enable_q;
        if (clk_en) begin
            if (bus.wr) begin
                unique case (bus.addr)
                    `SWK_ADDR_CONTROL: begin
                        ctrl_d.clk_src  = bus.wdata[`SWK_CTL_SRC];
                        ctrl_d.run      = bus.wdata[`SWK_CTL_RUN];
                        ctrl_d.prescale = bus.wdata[`SWK_CTL_PS_HI:`SWK_CTL_PS_LO];
                        // writing zero clears, writing one leaves it
                        flag_d = flag_q && bus.wdata[`SWK_CTL_FLAG];
                    end
                    `SWK_ADDR_RELOAD: reload_d = bus.wdata;
                    `SWK_ADDR_MASK:   mask_d = bus.wdata;
                    `SWK_ADDR_ENABLE: enable_d = bus.wdata[1:0];
                    default: ;
                endcase
            end
            if (bus.rd && bus.addr == `SWK_ADDR_STATUS) begin
                status_d = 8'h00;
            end
            // set after clear so a same-cycle overflow is kept
            if (overflow) begin
                flag_d = 1'b1;
                status_d[`SWK_ST_OVF] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q   <= swk_pkg::swk_ctrl_t'(5'h00);
            flag_q   <= 1'b0;
            reload_q <= `SWK_RST_RELOAD;
            status_q <= 8'h00;
            mask_q   <= 8'h00;
            enable_q <= 2'h0;
        end else begin
            ctrl_q   <= ctrl_d;
            flag_q   <= flag_d;
            reload_q <= reload_d;
            status_q <= status_d;
            mask_q   <= mask_d;
            enable_q <= enable_d;
        end
    end

    // ----------------------------------------
    // read data and outputs
    // ----------------------------------------
    always_comb begin
        rdata_d   = reg_rdata_q;
        irq_d     = irq_q;
        wake_d    = wake_request_q;
        rc_on_d   = rc_keep_on_q;
        xtal_on_d = xtal_keep_on_q;
        if (clk_en) begin
            rdata_d = 8'h00;
            if (bus.rd) begin
                unique case (bus.addr)
                    `SWK_ADDR_RELOAD:  rdata_d = reload_q;
                    `SWK_ADDR_CONTROL: rdata_d = {2'b00, ctrl_q.clk_src, flag_q, ctrl_q.run, ctrl_q.prescale};
                    `SWK_ADDR_STATUS:  rdata_d = status_q;
                    `SWK_ADDR_MASK:    rdata_d = mask_q;
                    `SWK_ADDR_ENABLE:  rdata_d = {6'h00, enable_q};
                    `SWK_ADDR_COUNT:   rdata_d = count_q;
                    default:           rdata_d = 8'h00;
                endcase
            end
            irq_d = (flag_q && enable_q[`SWK_EN_WAKE] && enable_q[`SWK_EN_GLOBAL])
                    || (|(status_q & mask_q));
            wake_d = flag_q && enable_q[`SWK_EN_WAKE] && low_power;
            // oscillator held on whenever running, low-power or not
            rc_on_d   = ctrl_q.run && !ctrl_q.clk_src;
            xtal_on_d = ctrl_q.run && ctrl_q.clk_src;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata_q    <= 8'h00;
            irq_q          <= 1'b0;
            wake_request_q <= 1'b0;
            rc_keep_on_q   <= 1'b0;
            xtal_keep_on_q <= 1'b0;
        end else begin
            reg_rdata_q    <= rdata_d;
            irq_q          <= irq_d;
            wake_request_q <= wake_d;
            rc_keep_on_q   <= rc_on_d;
            xtal_keep_on_q <= xtal_on_d;
        end
    end

endmodule : swk_top

// file: swk_defines.svh
`ifndef SWK_DEFINES_SVH
`define SWK_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SWK_ADDR_RELOAD  8'h86
`define SWK_ADDR_CONTROL 8'h8f
`define SWK_ADDR_STATUS  8'h90
`define SWK_ADDR_MASK    8'h91
`define SWK_ADDR_ENABLE  8'h92
`define SWK_ADDR_COUNT   8'h93

// ----------------------------------------
// control field positions
// ----------------------------------------
`define SWK_CTL_SRC      5
`define SWK_CTL_FLAG     4
`define SWK_CTL_RUN      3
`define SWK_CTL_PS_HI    2
`define SWK_CTL_PS_LO    0

// enable register bits
`define SWK_EN_WAKE      0
`define SWK_EN_GLOBAL    1

// status register bits
`define SWK_ST_OVF       0

// ----------------------------------------
// reset values and counter overflow top
// ----------------------------------------
`define SWK_RST_CONTROL  8'h00
`define SWK_RST_RELOAD   8'h00
`define SWK_RST_COUNT    8'h00
`define SWK_COUNT_TOP    8'hff

`endif

// file: swk_pkg.sv
package swk_pkg;

    typedef logic [2:0] swk_prescale_t;

    typedef struct packed {
        logic          clk_src;
        logic          run;
        swk_prescale_t prescale;
    } swk_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } swk_bus_t;

endpackage : swk_pkg

// file: swk_sync.sv
`timescale 1ns/1ps

module swk_sync (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = meta_q;
        sync_d = sync_q;
        if (clk_en) begin
            meta_d = async_in;
            sync_d = meta_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : swk_sync

// file: swk_prescale.sv
`timescale 1ns/1ps

module swk_prescale (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    input  wire logic                   run,
    input  wire logic                   src_edge,
    input  wire swk_pkg::swk_prescale_t prescale,
    output logic                        tick
);

    logic [10:0] div_q;
    logic [10:0] div_d;
    logic [10:0] limit;

    // ----------------------------------------
    // divide limit per setting
    // ----------------------------------------
    always_comb begin
        unique case (prescale)
            3'h0: limit = 11'h000;
            3'h1: limit = 11'h003;
            3'h2: limit = 11'h00f;
            3'h3: limit = 11'h03f;
            3'h4: limit = 11'h0ff;
            3'h5: limit = 11'h1ff;
            3'h6: limit = 11'h3ff;
            3'h7: limit = 11'h7ff;
        endcase
    end

    assign tick = run && src_edge && (div_q >= limit);

    always_comb begin
        div_d = div_q;
        // halted run holds the divider where it stood
        if (clk_en && run && src_edge) begin
            if (div_q >= limit) begin
                div_d = 11'h000;
            end else begin
                div_d = div_q + 11'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_q <= 11'h000;
        end else begin
            div_q <= div_d;
        end
    end

endmodule : swk_prescale

// file: swk_top_sva.sv
`timescale 1ns/1ps

module swk_top_sva (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic       internal_low_speed_rc,
    input wire logic       external_low_speed_crystal,
    input wire logic       cpu_idle,
    input wire logic       cpu_power_down,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       irq_q,
    input wire logic       wake_request_q,
    input wire logic       rc_keep_on_q,
    input wire logic       xtal_keep_on_q
);
    // ----------------------------------------
    // bus, interrupt, wake and keep-on relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_rdata_quiet: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata_q == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property ($past(reg_rd && reg_addr == 8'h55) |-> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_keep_excl: assert property (!(rc_keep_on_q && xtal_keep_on_q))
        else $error("both clock sources held on");
    a_keep_rise: assert property ($rose(rc_keep_on_q) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("rc keep-on rose without a write");
    a_keep_fall: assert property ($fell(rc_keep_on_q) || $fell(xtal_keep_on_q) |->
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("keep-on dropped without a write");
    a_irq_fall: assert property ($fell(irq_q) |-> $past(reg_wr || reg_rd) || $past(reg_wr || reg_rd, 2))
        else $error("interrupt dropped without software");
    a_wake_cause: assert property (wake_request_q |-> $past(cpu_idle || cpu_power_down))
        else $error("wake request outside low power");
    a_wake_fall: assert property ($fell(wake_request_q) |->
        $past(reg_wr) || $past(reg_wr, 2) || !$past(cpu_idle || cpu_power_down))
        else $error("wake request dropped by itself");

    c_irq: cover property ($rose(irq_q));
    c_wake: cover property ($rose(wake_request_q));
    c_xtal: cover property ($rose(xtal_keep_on_q));
endmodule : swk_top_sva

bind swk_top swk_top_sva swk_top_sva_i (.core_clk, .reset, .clk_en, .internal_low_speed_rc,
    .external_low_speed_crystal, .cpu_idle, .cpu_power_down, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .irq_q, .wake_request_q, .rc_keep_on_q, .xtal_keep_on_q);

// file: swk_top_tb.sv
`timescale 1ns/1ps

module swk_top_tb;
    typedef struct {logic [2:0] ps; logic src; int div; logic [7:0] ctl;} swk_row_t;
    logic       core_clk = 0, reset = 1, clk_en = 1, cpu_idle = 0, cpu_power_down = 0;
    logic       internal_low_speed_rc = 0, external_low_speed_crystal = 0;
    logic       reg_wr = 0, reg_rd = 0, irq_q, wake_request_q, rc_keep_on_q, xtal_keep_on_q;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q;
    int         failures = 0, n_checks = 0, cyc = 0;
    swk_row_t   rows [8] = '{'{0, 0, 1, 8'h18}, '{1, 1, 4, 8'h39}, '{2, 0, 16, 8'h1a},
        '{3, 1, 64, 8'h3b}, '{4, 0, 256, 8'h1c}, '{5, 1, 512, 8'h3d},
        '{6, 0, 1024, 8'h1e}, '{7, 1, 2048, 8'h3f}};

    swk_top swk_top_i (.core_clk, .reset, .clk_en, .internal_low_speed_rc,
        .external_low_speed_crystal, .cpu_idle, .cpu_power_down, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q, .irq_q, .wake_request_q, .rc_keep_on_q, .xtal_keep_on_q);

    always #12.5 core_clk = ~core_clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task results;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // a hang costs a mismatch, then the normal report
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            failures++;
            results();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task rst(input int n);
        @(posedge core_clk) reset <= 1;
        repeat (n) @(posedge core_clk);
        reset <= 0;
    endtask : rst

    task wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk) reg_wr <= 0;
    endtask : wrt

    task rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1;
        reg_addr <= a;
        @(posedge core_clk) reg_rd <= 0;
        #1 chk(reg_rdata_q, exp);
    endtask : rdc

    task settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle

    // half periods of three core cycles keep the source below core_clk/2
    task pulse(input logic s, input int n);
        repeat (n) begin
            @(posedge core_clk);
            if (s) external_low_speed_crystal <= 1; else internal_low_speed_rc <= 1;
            repeat (3) @(posedge core_clk);
            if (s) external_low_speed_crystal <= 0; else internal_low_speed_rc <= 0;
            repeat (2) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask : pulse

    initial begin
        rst(20);
        rdc(8'h86, 8'h00);
        rdc(8'h8f, 8'h00);
        rdc(8'h90, 8'h00);
        rdc(8'h91, 8'h00);
        rdc(8'h92, 8'h00);
        rdc(8'h93, 8'h00);
        rdc(8'h55, 8'h00);
        $display("test reset_values done");
        // reset per row so the shared divider starts from zero
        foreach (rows[i]) begin
            rst(2);
            wrt(8'h86, 8'hfe);
            wrt(8'h8f, {2'b00, rows[i].src, 5'h00});
            wrt(8'h8f, {2'b00, rows[i].src, 2'b01, rows[i].ps});
            pulse(rows[i].src, 2 * rows[i].div - 1);
            rdc(8'h8f, rows[i].ctl & 8'hef);
            pulse(rows[i].src, 1);
            rdc(8'h8f, rows[i].ctl);
            rdc(8'h93, 8'hfe);
        end
        $display("test prescale_rows done");
        rst(2);
        wrt(8'h86, 8'hfe);
        wrt(8'h8f, 8'h08);
        pulse(0, 1);
        rdc(8'h93, 8'hff);
        pulse(1, 2);
        rdc(8'h93, 8'hff);
        // clock enable low must freeze the synchronisers and the counter
        clk_en <= 0;
        pulse(0, 2);
        clk_en <= 1;
        settle();
        rdc(8'h93, 8'hff);
        wrt(8'h8f, 8'h00);
        pulse(0, 3);
        rdc(8'h93, 8'hff);
        wrt(8'h8f, 8'h08);
        pulse(0, 1);
        rdc(8'h93, 8'hfe);
        rdc(8'h8f, 8'h18);
        $display("test run_freeze done");
        rdc(8'h90, 8'h01);
        rdc(8'h90, 8'h00);
        wrt(8'h92, 8'h03);
        settle();
        chk({7'h00, irq_q}, 8'h01);
        wrt(8'h92, 8'h01);
        settle();
        chk({7'h00, irq_q}, 8'h00);
        cpu_idle <= 1;
        settle();
        chk({7'h00, wake_request_q}, 8'h01);
        chk({7'h00, rc_keep_on_q}, 8'h01);
        rdc(8'h8f, 8'h18);
        wrt(8'h8f, 8'h08);
        rdc(8'h8f, 8'h08);
        settle();
        chk({7'h00, wake_request_q}, 8'h00);
        wrt(8'h91, 8'h01);
        pulse(0, 2);
        chk({7'h00, irq_q}, 8'h01);
        rdc(8'h90, 8'h01);
        settle();
        chk({7'h00, irq_q}, 8'h00);
        cpu_idle       <= 0;
        cpu_power_down <= 1;
        pulse(0, 1);
        chk({7'h00, wake_request_q}, 8'h01);
        rdc(8'h93, 8'hff);
        $display("test interrupt_wake done");
        wrt(8'h8f, 8'h00);
        wrt(8'h8f, 8'h20);
        wrt(8'h8f, 8'h28);
        settle();
        chk({6'h00, xtal_keep_on_q, rc_keep_on_q}, 8'h02);
        wrt(8'h8f, 8'h20);
        settle();
        chk({6'h00, xtal_keep_on_q, rc_keep_on_q}, 8'h00);
        $display("test clock_source done");
        results();
    end
endmodule : swk_top_tb
